// *** include/rrw_pkg.sv ***
// Package with register map, field layout, reset values and timing for the receive window timers.
`default_nettype none
package rrw_pkg;
    // Register indices in the device address space.
    localparam logic [5:0] NO_REPLY_TIMEOUT_ADDR       = 6'h07;
    localparam logic [5:0] RECEIVE_BLANKING_TIME_ADDR  = 6'h08;
    localparam logic [5:0] RECEIVE_FILTER_SETTING_ADDR = 6'h09;
    localparam logic [5:0] RECEIVE_MIXER_GAIN_ADDR     = 6'h0A;

    // Reset values.
    localparam logic [7:0] NO_REPLY_TIMEOUT_RST        = 8'h0F;
    localparam logic [7:0] RECEIVE_BLANKING_TIME_RST   = 8'h07;
    localparam logic [7:0] RECEIVE_FILTER_SETTING_RST  = 8'h24;
    localparam logic [7:0] RECEIVE_MIXER_GAIN_RST      = 8'h01;

    // Field positions.
    localparam int FILTER_SKIP_SECOND_BIT = 7;
    localparam int FILTER_SKIP_FIRST_BIT  = 6;
    localparam int LOWPASS_CORNER_LSB     = 3;
    localparam int HIGHPASS_CORNER_LSB    = 0;
    localparam int BB_GAIN_LSB            = 6;
    localparam int BB_GAIN_SIGN_BIT       = 5;
    localparam int HYSTERESIS_LSB         = 2;
    localparam int MIXER_RANGE_LSB        = 0;
    localparam logic [2:0] HYSTERESIS_MAX = 3'h4;

    // Timing: step sizes in nanoseconds at a 50 MHz reference.
    localparam int CLK_PERIOD_NS     = 20;
    localparam int REPLY_STEP_NS     = 25600;
    localparam int BLANK_STEP_NS     = 6400;
    localparam int REPLY_LONG_NS     = 26200000;
    localparam int REPLY_STEP_CYC    = REPLY_STEP_NS / CLK_PERIOD_NS;
    localparam int BLANK_STEP_CYC    = BLANK_STEP_NS / CLK_PERIOD_NS;
    localparam int REPLY_LONG_CYC    = REPLY_LONG_NS / CLK_PERIOD_NS;
    localparam logic [7:0] REPLY_LONG_CODE = 8'hFF;
endpackage : rrw_pkg
`default_nettype wire

// *** rtl/rrw_timer.sv ***
// Receive response window timers and receive front-end setting registers.
// Operation
// - No-reply timer starts at end of transmit.
// - Codes 1..254 give N times 25.6 us.
// - Code 255 gives a 26.2 ms timeout.
// - Timeout event only before preamble is detected.
// - No-reply timeout resets to 15.
// - Receive input ignored during blanking time.
// - Codes 1..255 blank W times 6.4 us.
// - Code zero enables receiver immediately.
// - Blanking time resets to 7.
// - Baseband gain code is 3 dB steps.
// - Sign bit selects gain decrease or increase.
// - Mixer field selects gain by mixer type.
`timescale 1ns/10ps
`default_nettype none
module rrw_timer #(
    parameter int LONG_CYCLES = rrw_pkg::REPLY_LONG_CYC
) (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Register port.
    input  wire logic [5:0] regAddr,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regWdata,
    output var  logic [7:0] regRdata,
    output var  logic       regHit,
    // Link events.
    input  wire logic       txEnd,
    input  wire logic       preambleSeen,
    // Receiver control.
    output var  logic       rxEnable,
    output var  logic       noReplyIrq,
    output var  logic       replyWindowOpen,
    // Analog settings.
    output var  logic       filterSkipSecond,
    output var  logic       filterSkipFirst,
    output var  logic [2:0] lowpassCorner,
    output var  logic [2:0] highpassCorner,
    output var  logic [1:0] bbGainStep,
    output var  logic       bbGainIncrease,
    output var  logic [2:0] hysteresisStep,
    output var  logic [1:0] mixerRangeSelect
);
    // The timers count in 24 bits, so every limit must fit below this ceiling.
    localparam int CNT_MAX = 2**24 - 1;
    if (LONG_CYCLES < 1 || LONG_CYCLES > CNT_MAX) begin : g_long_range_check
        $error("LONG_CYCLES out of range");
    end
    if (rrw_pkg::REPLY_STEP_CYC * 254 > CNT_MAX) begin : g_reply_step_check
        $error("Reply step too long for the timer");
    end
    if (rrw_pkg::BLANK_STEP_CYC * 255 > CNT_MAX) begin : g_blank_step_check
        $error("Blanking step too long for the timer");
    end

    // Step sizes and the extended limit, in clock cycles.
    localparam logic [23:0] REPLY_STEP = 24'(rrw_pkg::REPLY_STEP_CYC);
    localparam logic [23:0] BLANK_STEP = 24'(rrw_pkg::BLANK_STEP_CYC);
    localparam logic [23:0] LONG_CNT   = 24'(LONG_CYCLES);

    logic [7:0]  replyTimeout_reg, replyTimeout_next;
    logic [7:0]  blankTime_reg, blankTime_next;
    logic [7:0]  filterSet_reg, filterSet_next;
    logic [7:0]  mixerGain_reg, mixerGain_next;
    logic [7:0]  regRdata_next;
    logic        regHit_next;
    logic [23:0] replyCnt_reg, replyCnt_next;
    logic        replyRun_reg, replyRun_next;
    logic [23:0] blankCnt_reg, blankCnt_next;
    logic        blankRun_reg, blankRun_next;
    logic        irq_reg, irq_next;
    logic [23:0] replyLimit;
    logic [23:0] blankLimit;
    logic [2:0]  hystStep_next;
    logic        rxEnable_next;
    logic        windowOpen_next;

    // Register file. A write and a read of one address in one cycle return the old value.
    always_comb begin
        replyTimeout_next = replyTimeout_reg;
        blankTime_next    = blankTime_reg;
        filterSet_next    = filterSet_reg;
        mixerGain_next    = mixerGain_reg;
        regRdata_next     = 8'h00;
        regHit_next       = 1'b0;
        // Writes to unmapped addresses are dropped; reading them returns zero and no hit.
        if (regWrite) begin
            unique case (regAddr)
                rrw_pkg::NO_REPLY_TIMEOUT_ADDR:       replyTimeout_next = regWdata;
                rrw_pkg::RECEIVE_BLANKING_TIME_ADDR:  blankTime_next    = regWdata;
                rrw_pkg::RECEIVE_FILTER_SETTING_ADDR: filterSet_next    = regWdata;
                rrw_pkg::RECEIVE_MIXER_GAIN_ADDR:     mixerGain_next    = regWdata;
                default: ;
            endcase
        end
        if (regRead) begin
            regHit_next = 1'b1;
            unique case (regAddr)
                rrw_pkg::NO_REPLY_TIMEOUT_ADDR:       regRdata_next = replyTimeout_reg;
                rrw_pkg::RECEIVE_BLANKING_TIME_ADDR:  regRdata_next = blankTime_reg;
                rrw_pkg::RECEIVE_FILTER_SETTING_ADDR: regRdata_next = filterSet_reg;
                rrw_pkg::RECEIVE_MIXER_GAIN_ADDR:     regRdata_next = mixerGain_reg;
                default: regHit_next = 1'b0;
            endcase
        end
        // Reserved hysteresis codes are clamped so the analog side never sees them.
        // The clamp sits before the flip-flop so the output stays a plain register.
        if (mixerGain_next[rrw_pkg::HYSTERESIS_LSB +: 3] > rrw_pkg::HYSTERESIS_MAX) begin
            hystStep_next = rrw_pkg::HYSTERESIS_MAX;
        end else begin
            hystStep_next = mixerGain_next[rrw_pkg::HYSTERESIS_LSB +: 3];
        end
    end

    // Register flip-flops; the hysteresis output is registered here as well.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            replyTimeout_reg <= rrw_pkg::NO_REPLY_TIMEOUT_RST;
            blankTime_reg    <= rrw_pkg::RECEIVE_BLANKING_TIME_RST;
            filterSet_reg    <= rrw_pkg::RECEIVE_FILTER_SETTING_RST;
            mixerGain_reg    <= rrw_pkg::RECEIVE_MIXER_GAIN_RST;
            regRdata         <= 8'h00;
            regHit           <= 1'b0;
            hysteresisStep   <= rrw_pkg::RECEIVE_MIXER_GAIN_RST[rrw_pkg::HYSTERESIS_LSB +: 3];
        end else begin
            replyTimeout_reg <= replyTimeout_next;
            blankTime_reg    <= blankTime_next;
            filterSet_reg    <= filterSet_next;
            mixerGain_reg    <= mixerGain_next;
            regRdata         <= regRdata_next;
            regHit           <= regHit_next;
            hysteresisStep   <= hystStep_next;
        end
    end

    // Limits are sampled each cycle; a rewrite mid-window changes the live window.
    always_comb begin
        if (replyTimeout_reg == rrw_pkg::REPLY_LONG_CODE) begin
            replyLimit = LONG_CNT;
        end else begin
            replyLimit = 24'(replyTimeout_reg * REPLY_STEP);
        end
        // A zero wait gives a zero limit, so the blanking timer never starts.
        blankLimit = 24'(blankTime_reg * BLANK_STEP);
    end

    always_comb begin
        replyCnt_next = replyCnt_reg;
        replyRun_next = replyRun_reg;
        blankCnt_next = blankCnt_reg;
        blankRun_next = blankRun_reg;
        irq_next      = 1'b0;
        // A new end of transmit restarts both timers, even inside an open window.
        if (txEnd) begin
            replyCnt_next = 24'h000000;
            replyRun_next = (replyLimit != 24'h000000);
            blankCnt_next = 24'h000000;
            blankRun_next = (blankLimit != 24'h000000);
        end else begin
            if (replyRun_reg) begin
                // The receive input is ignored while blanked, so no preamble counts then.
                if (preambleSeen && !blankRun_reg) begin
                    replyRun_next = 1'b0;
                // Comparing count plus one lands the event exactly limit cycles after txEnd.
                end else if (replyCnt_reg + 24'h000001 >= replyLimit) begin
                    replyRun_next = 1'b0;
                    irq_next      = 1'b1;
                end else begin
                    replyCnt_next = replyCnt_reg + 24'h000001;
                end
            end
            // The blanking timer only gates the receiver; it never raises an event.
            if (blankRun_reg) begin
                if (blankCnt_reg + 24'h000001 >= blankLimit) begin
                    blankRun_next = 1'b0;
                end else begin
                    blankCnt_next = blankCnt_reg + 24'h000001;
                end
            end
        end
        rxEnable_next   = !blankRun_next;
        windowOpen_next = replyRun_next;
    end

    // Timer flip-flops; the receiver outputs are registered copies of the next state.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            replyCnt_reg    <= 24'h000000;
            replyRun_reg    <= 1'b0;
            blankCnt_reg    <= 24'h000000;
            blankRun_reg    <= 1'b0;
            irq_reg         <= 1'b0;
            rxEnable        <= 1'b1;
            replyWindowOpen <= 1'b0;
        end else begin
            replyCnt_reg    <= replyCnt_next;
            replyRun_reg    <= replyRun_next;
            blankCnt_reg    <= blankCnt_next;
            blankRun_reg    <= blankRun_next;
            irq_reg         <= irq_next;
            rxEnable        <= rxEnable_next;
            replyWindowOpen <= windowOpen_next;
        end
    end

    // The timeout event is a one-cycle pulse; a host that polls must latch it elsewhere.
    assign noReplyIrq = irq_reg;

    // The analog settings are driven straight from the register flip-flops.
    // Their analog effect lies outside this logic; apart from the clamped hysteresis step, the bits pass on as written.
    assign filterSkipSecond = filterSet_reg[rrw_pkg::FILTER_SKIP_SECOND_BIT];
    assign filterSkipFirst  = filterSet_reg[rrw_pkg::FILTER_SKIP_FIRST_BIT];
    assign lowpassCorner    = filterSet_reg[rrw_pkg::LOWPASS_CORNER_LSB +: 3];
    assign highpassCorner   = filterSet_reg[rrw_pkg::HIGHPASS_CORNER_LSB +: 3];
    assign bbGainStep       = mixerGain_reg[rrw_pkg::BB_GAIN_LSB +: 2];
    assign bbGainIncrease   = mixerGain_reg[rrw_pkg::BB_GAIN_SIGN_BIT];
    assign mixerRangeSelect = mixerGain_reg[rrw_pkg::MIXER_RANGE_LSB +: 2];
endmodule : rrw_timer
`default_nettype wire

// *** verif/rrw_tag_model.sv ***
// Behavioural tag reply that flags a detected preamble a set time after transmit ends.
`timescale 1ns/10ps
`default_nettype none
module rrw_tag_model (
    // Clock, reset and link event.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        txEnd,
    // Reply delay in cycles; zero keeps the tag silent.
    input  wire logic [15:0] replyDelay,
    output var  logic        preambleSeen
);
    int age;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            age <= 0;
        end else begin
            age <= txEnd ? 1 : age + 1;
        end
    end
    // One flag per command, as the decoder locks once on a preamble.
    assign preambleSeen = replyDelay != 16'h0 && age == int'(replyDelay);
endmodule : rrw_tag_model
`default_nettype wire

// *** verif/rrw_timer_asserts.sv ***
// Concurrent checks on the receive window timers.
`timescale 1ns/10ps
`default_nettype none
module rrw_timer_asserts #(
    parameter int LONG_CYCLES = rrw_pkg::REPLY_LONG_CYC
) (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Register port.
    input  wire logic [5:0] regAddr,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regWdata,
    input  wire logic [7:0] regRdata,
    input  wire logic       regHit,
    // Link events and receiver control.
    input  wire logic       txEnd,
    input  wire logic       preambleSeen,
    input  wire logic       rxEnable,
    input  wire logic       noReplyIrq,
    input  wire logic       replyWindowOpen
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [7:0]  ntoReg, ntoNext, wtReg, wtNext;
    logic [21:0] ageReg, ageNext;
    always_comb begin
        ntoNext = (regWrite && regAddr == rrw_pkg::NO_REPLY_TIMEOUT_ADDR) ? regWdata : ntoReg;
        wtNext  = (regWrite && regAddr == rrw_pkg::RECEIVE_BLANKING_TIME_ADDR) ? regWdata : wtReg;
        ageNext = txEnd ? 22'h0 : ageReg + 22'h1;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ntoReg <= rrw_pkg::NO_REPLY_TIMEOUT_RST;
            wtReg  <= rrw_pkg::RECEIVE_BLANKING_TIME_RST;
            ageReg <= 22'h0;
        end else begin
            ntoReg <= ntoNext;
            wtReg  <= wtNext;
            ageReg <= ageNext;
        end
    end
    sequence s_tx_blank;
        txEnd && wtReg != 8'h00;
    endsequence
    a_blank_start: assert property (s_tx_blank |=> !rxEnable)
        else $error("Receiver not blanked after transmit.");
    a_no_blank: assert property (txEnd && wtReg == 8'h00 |=> rxEnable)
        else $error("Receiver blanked with zero wait.");
    a_rx_reopen: assert property ($rose(rxEnable) |-> int'(ageReg) == int'(wtReg) * 320)
        else $error("Blanking length wrong.");
    a_irq_timing: assert property (noReplyIrq |-> int'(ageReg) ==
        (ntoReg == 8'hFF ? LONG_CYCLES : int'(ntoReg) * 1280)) else $error("Timeout length wrong.");
    sequence s_irq_close;
        !replyWindowOpen ##1 !noReplyIrq;
    endsequence
    a_irq_pulse: assert property (noReplyIrq |-> s_irq_close)
        else $error("Timeout event malformed.");
    a_tx_window: assert property (txEnd && ntoReg != 8'h00 |=> replyWindowOpen)
        else $error("Reply window not opened.");
    a_preamble_stop: assert property (replyWindowOpen && rxEnable && preambleSeen && !txEnd
        |=> !replyWindowOpen && !noReplyIrq) else $error("Preamble did not stop timer.");
    a_read_back: assert property (regRead && !regWrite
        && regAddr == rrw_pkg::NO_REPLY_TIMEOUT_ADDR |=> regHit && regRdata == $past(ntoReg))
        else $error("Timeout register read wrong.");
endmodule : rrw_timer_asserts
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking testbench for the receive window timers.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        ref_clk, rst, regWrite, regRead, txEnd, regHit, preambleSeen;
    logic        rxEnable, noReplyIrq, replyWindowOpen, skip2, skip1, gainUp;
    logic [5:0]  regAddr;
    logic [7:0]  regWdata, regRdata;
    logic [2:0]  lowC, highC, hyst;
    logic [1:0]  gain, mix;
    logic [15:0] replyDelay;
    int          n_mismatch = 0, cmp_count = 0, n, i;
    rrw_timer #(.LONG_CYCLES(2000)) u_rrw_timer (.ref_clk(ref_clk), .rst(rst),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regRdata(regRdata), .regHit(regHit), .txEnd(txEnd), .preambleSeen(preambleSeen),
        .rxEnable(rxEnable), .noReplyIrq(noReplyIrq), .replyWindowOpen(replyWindowOpen),
        .filterSkipSecond(skip2), .filterSkipFirst(skip1), .lowpassCorner(lowC),
        .highpassCorner(highC), .bbGainStep(gain), .bbGainIncrease(gainUp),
        .hysteresisStep(hyst), .mixerRangeSelect(mix));
    rrw_tag_model u_rrw_tag_model (.ref_clk(ref_clk), .rst(rst), .txEnd(txEnd),
        .replyDelay(replyDelay), .preambleSeen(preambleSeen));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge ref_clk);
        regWrite = 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic h);
        @(negedge ref_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge ref_clk);
        regRead = 1'b0;
        chk({regHit, regRdata}, {h, e});
    endtask : rd
    // Counts cycles from the transmit end to reopening and to the timeout event.
    task automatic run(input int blank, input int irqAt);
        @(negedge ref_clk);
        txEnd = 1'b1;
        @(negedge ref_clk);
        txEnd = 1'b0;
        n = 0;
        while (rxEnable !== 1'b1 && n < 20000) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n, blank);
        while (noReplyIrq !== 1'b1 && n < 20000) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n, irqAt);
    endtask : run
    task automatic end_of_test();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #1200000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {rst, regWrite, regRead, txEnd, regAddr, regWdata, replyDelay} = {1'b1, 33'h0};
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        rd(6'h07, 8'h0F, 1'b1);
        rd(6'h08, 8'h07, 1'b1);
        rd(6'h3F, 8'h00, 1'b0);
        chk({skip2, skip1, lowC, highC}, 8'h24);
        chk({gain, gainUp, hyst, mix}, 8'h01);
        run(2240, 19200);
        wr(6'h07, 8'h01);
        wr(6'h08, 8'h01);
        run(320, 1280);
        wr(6'h07, 8'hFF);
        wr(6'h08, 8'h00);
        run(0, 2000);
        wr(6'h07, 8'h02);
        wr(6'h08, 8'h01);
        replyDelay = 16'h01F4;
        run(320, 20000);
        chk(replyWindowOpen, 1'b0);
        replyDelay = 16'h0064;
        run(320, 2560);
        txEnd = 1'b1;
        @(negedge ref_clk);
        txEnd = 1'b0;
        repeat (100) @(negedge ref_clk);
        chk({replyWindowOpen, rxEnable}, 2'b10);
        run(320, 2560);
        wr(6'h09, 8'hFF);
        chk({skip2, skip1, lowC, highC}, 8'hFF);
        rd(6'h09, 8'hFF, 1'b1);
        for (i = 0; i < 5; i++) begin
            wr(6'h0A, {i[1:0], i[0], i[2:0], i[1:0]});
            chk({gain, gainUp, hyst, mix}, {i[1:0], i[0], i[2:0], i[1:0]});
        end
        rd(6'h0A, 8'h10, 1'b1);
        end_of_test();
    end
endmodule : testbench
bind rrw_timer rrw_timer_asserts #(.LONG_CYCLES(LONG_CYCLES)) u_rrw_timer_asserts (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit), .txEnd(txEnd),
    .preambleSeen(preambleSeen), .rxEnable(rxEnable), .noReplyIrq(noReplyIrq),
    .replyWindowOpen(replyWindowOpen));
`default_nettype wire
